// ===== include/usage_regs_pkg.sv
// Constants and types shared by the selector and cache usage register logic.
// What this block does
// R1: Four-bit resource index, zero when unsupported.
// R2: Sixteen-bit monitor index; other selector bits zero.
// R3: Monitor registers follow index and access space.
// R4: Four separate selectors, one per space.
// R5: Selector at 0x0800, readable and writable.
// R6: Readout absent unless both monitoring flags set.
// R7: Bit 31 flags the count as not ready.
// R8: Bits 30:0 hold usage bytes when ready.
// R9: Resource index joins monitor index when supported.
// R10: Four readout copies, each by own selector.
// R11: Readout at 0x0840; writes obey read-only capability.
// R12: Root and fourth copies need four-space extension.
// R13: Out-of-range monitor index raises an error.
// R14: New selector value applies to next access.
package usage_regs_pkg;
    localparam int          DATA_W          = 32;
    localparam int          OFS_W           = 12;
    localparam int          SPACE_COUNT     = 4;
    localparam int          RES_W           = 4;
    localparam int          MON_W           = 16;
    localparam int          USAGE_W         = 31;
    localparam logic [11:0] OFS_SELECTOR    = 12'h800;
    localparam logic [11:0] OFS_USAGE       = 12'h840;
    localparam int          SEL_RES_LSB     = 24;
    localparam int          SEL_MON_LSB     = 0;
    localparam int          NOT_READY_BIT   = 31;
    localparam logic [3:0]  RES_RESET       = 4'h0;
    localparam logic [15:0] MON_RESET       = 16'h0000;
    localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
    localparam logic [31:0] WORD_NOT_READY  = 32'h8000_0000;

    typedef enum logic [1:0] {
        SPACE_SECURE    = 2'b00,
        SPACE_NONSECURE = 2'b01,
        SPACE_ROOT      = 2'b10,
        SPACE_FOURTH    = 2'b11
    } space_e;
endpackage : usage_regs_pkg

// ===== include/usage_store_if.sv
// Interface between the register logic and the usage word store.
`timescale 1ns/100ps
`default_nettype none
interface usage_store_if #(
    parameter int IDX_W = 8
);
    logic [IDX_W-1:0] rd_idx;
    logic [31:0]      rd_word;
    logic             wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [31:0]      wr_word;
    logic             upd_en;
    logic [IDX_W-1:0] upd_idx;
    logic [31:0]      upd_word;

    modport store (input rd_idx, output rd_word, input wr_en, input wr_idx, input wr_word,
                   input upd_en, input upd_idx, input upd_word);
    modport user (output rd_idx, input rd_word, output wr_en, output wr_idx, output wr_word,
                  output upd_en, output upd_idx, output upd_word);
endinterface : usage_store_if
`default_nettype wire

// ===== logic/usage_store.sv
// Storage of one usage word per space, resource and monitor instance.
`timescale 1ns/100ps
`default_nettype none
module usage_store
    import usage_regs_pkg::*;
#(
    parameter int DEPTH = 64,
    parameter int IDX_W = 6
) (
    input  wire logic    clk,
    input  wire logic    srst,
    usage_store_if.store bus
);
    logic [31:0]      mem [DEPTH];
    logic [DEPTH-1:0] loaded_ff;

    // Entries never written report not ready with a zero count.
    assign bus.rd_word = loaded_ff[bus.rd_idx] ? mem[bus.rd_idx] : WORD_NOT_READY; // R7

    // The counting update wins over a software write to the same entry.
    always_ff @(posedge clk) begin
        if (bus.wr_en && !(bus.upd_en && bus.upd_idx == bus.wr_idx)) begin
            mem[bus.wr_idx] <= bus.wr_word;
        end
        if (bus.upd_en) begin
            mem[bus.upd_idx] <= bus.upd_word;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            loaded_ff <= '0;
        end else begin
            if (bus.wr_en) begin
                loaded_ff[bus.wr_idx] <= 1'b1;
            end
            if (bus.upd_en) begin
                loaded_ff[bus.upd_idx] <= 1'b1;
            end
        end
    end
endmodule : usage_store
`default_nettype wire

// ===== logic/usage_regs.sv
// Per-space monitor selector and cache usage readout registers.
`timescale 1ns/100ps
`default_nettype none
module usage_regs
    import usage_regs_pkg::*;
#(
    parameter int MON_COUNT                = 8,
    parameter int RES_COUNT                = 2,
    parameter bit VERSION_SUPPORTED        = 1'b1,
    parameter bit EXTENDED_ID_FLAG         = 1'b1,
    parameter bit RESOURCE_SELECT_SUPPORTED = 1'b1,
    parameter bit MONITORING_SUPPORTED     = 1'b1,
    parameter bit CACHE_USAGE_MONITOR_FLAG = 1'b1,
    parameter bit READOUT_READ_ONLY_CAP    = 1'b0,
    parameter bit FOUR_SPACE_EXTENSION     = 1'b1
) (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               acc_valid,
    input  wire logic               acc_write,
    input  wire logic [1:0]         acc_space,
    input  wire logic [OFS_W-1:0]   acc_offset,
    input  wire logic [DATA_W-1:0]  acc_wdata,
    output logic [DATA_W-1:0]       rd_data,
    output logic                    rd_valid,
    output logic                    oob_error,
    input  wire logic               upd_valid,
    input  wire logic [1:0]         upd_space,
    input  wire logic [RES_W-1:0]   upd_res,
    input  wire logic [MON_W-1:0]   upd_mon,
    input  wire logic               upd_not_ready,
    input  wire logic [USAGE_W-1:0] upd_usage
);
    localparam int DEPTH = SPACE_COUNT * RES_COUNT * MON_COUNT;
    localparam int IDX_W = $clog2(DEPTH);
    localparam bit RES_ON = VERSION_SUPPORTED && EXTENDED_ID_FLAG && RESOURCE_SELECT_SUPPORTED;

    logic [RES_W-1:0]  res_ff [SPACE_COUNT];
    logic [MON_W-1:0]  mon_ff [SPACE_COUNT];
    logic [DATA_W-1:0] rd_data_ff;
    logic              rd_valid_ff;
    logic              oob_error_ff;

    // Flat store index of one space, resource and monitor instance.
    function automatic logic [IDX_W-1:0] entry_idx(input logic [1:0] space, input logic [RES_W-1:0] res,
                                                   input logic [MON_W-1:0] mon);
        int flat;
        flat = (int'(space) * RES_COUNT + int'(res)) * MON_COUNT + int'(mon);
        return IDX_W'(flat);
    endfunction : entry_idx

    // True when a resource and monitor pair lies inside the store.
    function automatic logic in_range(input logic [RES_W-1:0] res, input logic [MON_W-1:0] mon);
        return (int'(mon) < MON_COUNT) && (int'(res) < RES_COUNT);
    endfunction : in_range

    // True when the readout copy of a space exists.
    function automatic logic usage_exists(input logic [1:0] space);
        return MONITORING_SUPPORTED && CACHE_USAGE_MONITOR_FLAG &&
               (space == SPACE_SECURE || space == SPACE_NONSECURE || FOUR_SPACE_EXTENSION);
    endfunction : usage_exists

    usage_store_if #(.IDX_W(IDX_W)) store_bus ();

    usage_store #(
        .DEPTH (DEPTH),
        .IDX_W (IDX_W)
    ) u_store (
        .clk  (clk),
        .srst (srst),
        .bus  (store_bus)
    );

    wire              rd_req      = acc_valid && !acc_write;
    wire              sel_hit     = acc_valid && acc_offset == OFS_SELECTOR; // R5
    wire              usage_hit   = acc_valid && acc_offset == OFS_USAGE; // R11
    wire              usage_live  = usage_exists(acc_space); // R6 R12
    wire [RES_W-1:0]  cur_res     = res_ff[acc_space]; // R4 R10
    wire [MON_W-1:0]  cur_mon     = mon_ff[acc_space]; // R3
    wire              cur_inrange = in_range(cur_res, cur_mon); // R13
    wire              usage_open  = usage_hit && usage_live && cur_inrange;
    wire [RES_W-1:0]  wr_res      = RES_ON ? acc_wdata[SEL_RES_LSB +: RES_W] : RES_RESET; // R1
    wire [MON_W-1:0]  wr_mon      = acc_wdata[SEL_MON_LSB +: MON_W]; // R2
    wire [RES_W-1:0]  upd_res_eff = RES_ON ? upd_res : RES_RESET; // R9

    wire [DATA_W-1:0] sel_word    = {{(DATA_W - SEL_RES_LSB - RES_W){1'b0}}, cur_res,
                                     {(SEL_RES_LSB - MON_W){1'b0}}, cur_mon}; // R2
    // Writes give no answer, so the read data only carries a word for reads.
    wire [DATA_W-1:0] nxt_rd_data = (rd_req && sel_hit)    ? sel_word :
                                    (rd_req && usage_open) ? store_bus.rd_word : WORD_ZERO; // R6 R7 R8
    wire              nxt_rd_valid  = rd_req;
    wire              nxt_oob_error = usage_hit && usage_live && !cur_inrange; // R13

    assign store_bus.rd_idx   = entry_idx(acc_space, cur_res, cur_mon); // R9 R14
    assign store_bus.wr_en    = usage_open && acc_write && !READOUT_READ_ONLY_CAP; // R11
    assign store_bus.wr_idx   = entry_idx(acc_space, cur_res, cur_mon);
    assign store_bus.wr_word  = acc_wdata;
    assign store_bus.upd_en   = upd_valid && in_range(upd_res_eff, upd_mon);
    assign store_bus.upd_idx  = entry_idx(upd_space, upd_res_eff, upd_mon);
    assign store_bus.upd_word = {upd_not_ready, upd_usage}; // R7 R8

    always_ff @(posedge clk) begin
        for (int s = 0; s < SPACE_COUNT; s++) begin
            if (srst) begin
                res_ff[s] <= RES_RESET;
                mon_ff[s] <= MON_RESET;
            end else if (sel_hit && acc_write && acc_space == 2'(s)) begin
                res_ff[s] <= wr_res; // R1 R4 R14
                mon_ff[s] <= wr_mon; // R2
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rd_data_ff   <= WORD_ZERO;
            rd_valid_ff  <= 1'b0;
            oob_error_ff <= 1'b0;
        end else begin
            rd_data_ff   <= nxt_rd_data;
            rd_valid_ff  <= nxt_rd_valid;
            oob_error_ff <= nxt_oob_error;
        end
    end

    assign rd_data   = rd_data_ff;
    assign rd_valid  = rd_valid_ff;
    assign oob_error = oob_error_ff;
endmodule : usage_regs
`default_nettype wire

// ===== verif/usage_regs_assertions.sv
// Checker for the selector and cache usage register ports.
`timescale 1ns/100ps
`default_nettype none
module usage_regs_chk
    import usage_regs_pkg::*;
#(parameter int MON_COUNT = 8, parameter int RES_COUNT = 2) (
    input wire logic              clk,
    input wire logic              srst,
    input wire logic              acc_valid,
    input wire logic              acc_write,
    input wire logic [1:0]        acc_space,
    input wire logic [OFS_W-1:0]  acc_offset,
    input wire logic [DATA_W-1:0] acc_wdata,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic              rd_valid,
    input wire logic              oob_error,
    input wire logic              upd_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire rd = acc_valid && !acc_write;
    wire wr = acc_valid && acc_write;
    a_read_answer: assert property (rd |=> rd_valid) else $error("read not answered");
    a_write_silent: assert property (!rd |=> !rd_valid && rd_data == 32'h0) else $error("stray answer");
    a_reserved_zero: assert property (rd && acc_offset == OFS_SELECTOR |=> rd_data[31:28] == 4'h0
        && rd_data[23:16] == 8'h00) else $error("reserved selector bits set");
    a_sel_next_use: assert property (wr && acc_offset == OFS_SELECTOR ##1 rd && acc_offset == OFS_SELECTOR
        && acc_space == $past(acc_space) |=> rd_data == ($past(acc_wdata, 2) & 32'h0f00_ffff))
        else $error("selector readback wrong");
    a_unmapped_zero: assert property (rd && acc_offset != OFS_SELECTOR && acc_offset != OFS_USAGE
        |=> rd_data == 32'h0) else $error("unmapped read not zero");
    a_oob_cause: assert property (oob_error |-> $past(acc_valid) && $past(acc_offset) == OFS_USAGE)
        else $error("error without readout access");
    a_oob_zero: assert property (oob_error && rd_valid |-> rd_data == 32'h0) else $error("oob data");
    a_readout_back: assert property (wr && acc_offset == OFS_USAGE && !upd_valid ##1 rd
        && acc_offset == OFS_USAGE && acc_space == $past(acc_space) && !oob_error
        |=> oob_error || rd_data == $past(acc_wdata, 2)) else $error("readout write lost");
    c_usage_read: cover property (rd && acc_offset == OFS_USAGE);
    c_oob: cover property (oob_error);
    c_sel_write: cover property (wr && acc_offset == OFS_SELECTOR);
endmodule : usage_regs_chk
bind usage_regs usage_regs_chk #(.MON_COUNT(MON_COUNT), .RES_COUNT(RES_COUNT)) usage_regs_chk_inst (.clk,
    .srst, .acc_valid, .acc_write, .acc_space, .acc_offset, .acc_wdata, .rd_data, .rd_valid, .oob_error,
    .upd_valid);
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the selector and cache usage registers.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import usage_regs_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, acc_valid = 1'b0, acc_write = 1'b0, upd_valid = 1'b0, upd_not_ready, rd_valid;
    logic [1:0] acc_space = 2'h0, upd_space = 2'h0;
    logic [OFS_W-1:0] acc_offset = 12'h000;
    logic [DATA_W-1:0] acc_wdata = 32'h0, rd_data;
    logic [RES_W-1:0] upd_res = 4'h0;
    logic [MON_W-1:0] upd_mon = 16'h0;
    logic [USAGE_W-1:0] upd_usage = 31'h0;
    logic oob_error;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    always #25 clk = ~clk;
    initial upd_not_ready = 1'b0;
    usage_regs usage_regs_inst (.clk, .srst, .acc_valid, .acc_write, .acc_space, .acc_offset, .acc_wdata,
        .rd_data, .rd_valid, .oob_error, .upd_valid, .upd_space, .upd_res, .upd_mon, .upd_not_ready, .upd_usage);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task acc(input logic w, input logic [1:0] sp, input logic [11:0] ofs, input logic [31:0] d);
        acc_valid = 1'b1;
        acc_write = w;
        acc_space = sp;
        acc_offset = ofs;
        acc_wdata = d;
        @(posedge clk);
        #1;
    endtask : acc
    task rd(input logic [1:0] sp, input logic [11:0] ofs, input logic [31:0] exp, input logic oob);
        acc(1'b0, sp, ofs, 32'h0);
        chk({31'h0, rd_valid}, 32'h1);
        chk(rd_data, exp);
        chk({31'h0, oob_error}, {31'h0, oob});
    endtask : rd
    task idle;
        acc_valid = 1'b0;
        @(posedge clk);
        #1;
    endtask : idle
    task upd(input logic [1:0] sp, input logic [3:0] r, input logic [15:0] m, input logic nr,
             input logic [30:0] u);
        acc_valid = 1'b0;
        upd_valid = 1'b1;
        upd_space = sp;
        upd_res = r;
        upd_mon = m;
        upd_not_ready = nr;
        upd_usage = u;
        @(posedge clk);
        #1;
        upd_valid = 1'b0;
    endtask : upd
    task test_reset;
        for (int s = 0; s < 4; s++) begin
            rd(s[1:0], OFS_SELECTOR, 32'h0, 1'b0);
            rd(s[1:0], OFS_USAGE, WORD_NOT_READY, 1'b0);
        end
        idle;
    endtask : test_reset
    task test_fields;
        acc(1'b1, 2'h1, OFS_SELECTOR, 32'hffff_ffff);
        rd(2'h1, OFS_SELECTOR, 32'h0f00_ffff, 1'b0);
        rd(2'h0, OFS_SELECTOR, 32'h0, 1'b0);
        rd(2'h1, 12'h844, 32'h0, 1'b0);
        idle;
    endtask : test_fields
    task test_update;
        upd(2'h2, 4'h1, 16'h0003, 1'b0, 31'h0001_2345);
        acc(1'b1, 2'h2, OFS_SELECTOR, 32'h0100_0003);
        rd(2'h2, OFS_USAGE, 32'h0001_2345, 1'b0);
        acc(1'b1, 2'h0, OFS_SELECTOR, 32'h0100_0003);
        rd(2'h0, OFS_USAGE, WORD_NOT_READY, 1'b0);
        acc(1'b1, 2'h2, OFS_SELECTOR, 32'h0000_0003);
        rd(2'h2, OFS_USAGE, WORD_NOT_READY, 1'b0);
        upd(2'h2, 4'h0, 16'h0003, 1'b1, 31'h0000_0055);
        rd(2'h2, OFS_USAGE, 32'h8000_0055, 1'b0);
        idle;
    endtask : test_update
    task test_writeback;
        acc(1'b1, 2'h3, OFS_USAGE, 32'h7fff_0001);
        rd(2'h3, OFS_USAGE, 32'h7fff_0001, 1'b0);
        rd(2'h2, OFS_USAGE, 32'h8000_0055, 1'b0);
        idle;
    endtask : test_writeback
    task test_oob;
        acc(1'b1, 2'h0, OFS_SELECTOR, 32'h0000_0008);
        rd(2'h0, OFS_USAGE, 32'h0, 1'b1);
        acc(1'b1, 2'h0, OFS_SELECTOR, 32'h0200_0000);
        rd(2'h0, OFS_USAGE, 32'h0, 1'b1);
        idle;
    endtask : test_oob
    task wrap_up;
        $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    always @(posedge clk) begin
        cyc++;
        if (cyc == 1000) begin
            bad_count++;
            wrap_up;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        idle;
        test_reset;
        test_fields;
        test_update;
        test_writeback;
        test_oob;
        wrap_up;
    end
endmodule : testbench
`default_nettype wire
